// ### design/csmux_cfg.svh
`ifndef CSMUX_CFG_SVH
`define CSMUX_CFG_SVH
// Fixed upper five bits of the slave address.
`define CSMUX_ADDR_FIXED 5'h13
// Store width and reset contents.
`define CSMUX_STORE_W 6
`define CSMUX_STORE_RST 6'h00
// Data byte field positions: held bit, then five selected bits.
`define CSMUX_HELD_BIT 5
`define CSMUX_SEL_LSB 0
`define CSMUX_SEL_MSB 4
`endif

// ### design/csmux_pkg.sv
`default_nettype none
package csmux_pkg;
	// Pin inputs after synchronisation.
	typedef struct packed {
		logic       force_n;
		logic       write_lock;
		logic       source_select;
		logic [4:0] bypass_inputs;
	} csmux_pins_t;
	// Serial bus states.
	typedef enum logic [2:0] {
		CSMUX_IDLE, CSMUX_ADDR, CSMUX_AACK, CSMUX_DATA, CSMUX_DACK,
		CSMUX_WAIT
	} csmux_state_t;
endpackage : csmux_pkg
`default_nettype wire

// ### design/csmux_sync.sv
`default_nettype none
module csmux_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	// ------------------------------------------------------------------
	// Two-stage synchroniser; reset value is all ones, matching pull-ups.
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			meta <= '1;
			q_o  <= '1;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : csmux_sync
`default_nettype wire

// ### design/csmux_store.sv
`default_nettype none
`include "csmux_cfg.svh"
module csmux_store #(
	parameter int W = `CSMUX_STORE_W
) (
	input  wire logic         clk_i,
	input  wire logic         nv_rstn_i,
	input  wire logic         we_i,
	input  wire logic [W-1:0] wdata_i,
	output var  logic [W-1:0] rdata_o
);
	// ------------------------------------------------------------------
	// Non-volatile cell model: cleared only by the factory erase input,
	// not by the ordinary reset, so contents survive a power cycle.
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!nv_rstn_i) begin
			rdata_o <= W'(`CSMUX_STORE_RST);
		end else if (we_i) begin
			rdata_o <= wdata_i;
		end
	end
endmodule : csmux_store
`default_nettype wire

// ### design/csmux_top.sv
`default_nettype none
`include "csmux_cfg.svh"
//Contract
//- Select low: outputs follow store bits.
//- Select high: selected outputs follow bypass pins.
//- Held output latch transparent while select low.
//- Force low, select low: all outputs zero.
//- Force low, select high: bypass, held kept.
//- Write lock high refuses store writes.
//- Write only with direction zero, lock low.
//- Direction one returns store in data byte.
//- Store starts as all zeros.
//- Undriven inputs read as one.
//- Address: five fixed, two pin, direction.
//- Exactly one data byte per transfer.
//- High bit held, low five selected.
//- Low supply blocks store writes.
//- Reset initialises bus logic and registers.
//- After reset outputs follow force and select.
//- Store keeps last write across power loss.
module csmux_top (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       nv_erase_n_i,
	input  wire logic       supply_ok_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	input  wire logic       bus_addr_pin_low_i,
	input  wire logic       bus_addr_pin_high_i,
	input  wire logic       force_n_i,
	input  wire logic       write_lock_i,
	input  wire logic       source_select_i,
	input  wire logic [4:0] bypass_inputs_i,
	output var  logic [4:0] selected_outputs_o,
	output var  logic [4:0] selected_outputs_oe_o,
	output var  logic       held_output_o,
	output var  logic       held_output_oe_o
);
	localparam int SW = `CSMUX_STORE_W;
	csmux_pkg::csmux_pins_t pins;
	csmux_pkg::csmux_state_t state;
	logic [1:0] apin;
	logic       scl_s, sda_s, scl_d, sda_d;
	logic       sup_s;
	logic       addr_full;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic       rw;
	logic       sda_low;
	logic [SW-1:0] store_q;
	logic       held_q;
	logic       st_we;
	// ------------------------------------------------------------------
	// Input synchronisers.
	// ------------------------------------------------------------------
	// Pull-ups are modelled by an all-ones reset value and by the bench.
	csmux_sync #(.W(8)) u_pin_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      ({force_n_i, write_lock_i, source_select_i,
			bypass_inputs_i}),
		.q_o      (pins)
	);
	// The supply monitor is asynchronous too, so it shares this stage.
	csmux_sync #(.W(5)) u_bus_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      ({scl_i, sda_i, supply_ok_i, bus_addr_pin_high_i,
			bus_addr_pin_low_i}),
		.q_o      ({scl_s, sda_s, sup_s, apin})
	);
	// ------------------------------------------------------------------
	// Bus edge and condition detection.
	// ------------------------------------------------------------------
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
	wire [7:0] shifted = {shreg[6:0], sda_s};
	// The full address byte sits in shreg at the fall after its eighth bit.
	wire addr_hit = (shreg[7:1] == {`CSMUX_ADDR_FIXED, apin});
	// Write gate: direction zero, lock low, supply good.
	wire wr_ok = ~rw & ~pins.write_lock & sup_s;
	// Read byte: the two unused top bits always read as zero.
	wire [7:0] rd_byte = {2'h0, store_q};
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end
	// ------------------------------------------------------------------
	// Serial bus state machine.
	// ------------------------------------------------------------------
	// Reset returns every bus register to its idle value.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state   <= csmux_pkg::CSMUX_IDLE;
			bit_cnt <= 3'h0;
			shreg   <= 8'h00;
			rw        <= 1'b0;
			sda_low   <= 1'b0;
			st_we     <= 1'b0;
			addr_full <= 1'b0;
		end else begin
			st_we <= 1'b0;
			if (start_c) begin
				state     <= csmux_pkg::CSMUX_ADDR;
				bit_cnt   <= 3'h0;
				sda_low   <= 1'b0;
				addr_full <= 1'b0;
			end else if (stop_c) begin
				state   <= csmux_pkg::CSMUX_IDLE;
				sda_low <= 1'b0;
			end else begin
				case (state)
				csmux_pkg::CSMUX_ADDR: begin
					// The first fall after START carries no bit, so the
					// byte is judged only once eight rises were seen.
					if (scl_rise) begin
						shreg     <= shifted;
						bit_cnt   <= bit_cnt + 3'h1;
						addr_full <= (bit_cnt == 3'h7);
					end
					if (scl_fall && addr_full) begin
						addr_full <= 1'b0;
						if (addr_hit) begin
							rw      <= shreg[0];
							sda_low <= 1'b1;
							state   <= csmux_pkg::CSMUX_AACK;
						end else begin
							state <= csmux_pkg::CSMUX_WAIT;
						end
					end
				end
				csmux_pkg::CSMUX_AACK: begin
					if (scl_fall) begin
						state   <= csmux_pkg::CSMUX_DATA;
						bit_cnt <= 3'h0;
						// Read drives the top bit of the read byte first.
						shreg   <= rd_byte;
						sda_low <= rw & ~rd_byte[7];
					end
				end
				csmux_pkg::CSMUX_DATA: begin
					if (scl_rise) begin
						if (!rw) begin
							shreg <= shifted;
						end
						bit_cnt <= bit_cnt + 3'h1;
					end
					if (scl_fall) begin
						if (rw) begin
							if (bit_cnt == 3'h0) begin
								sda_low <= 1'b0;
								state   <= csmux_pkg::CSMUX_DACK;
							end else begin
								shreg   <= {shreg[6:0], 1'b0};
								sda_low <= ~shreg[6];
							end
						end else if (bit_cnt == 3'h0) begin
							sda_low <= 1'b1;
							st_we   <= wr_ok;
							state   <= csmux_pkg::CSMUX_DACK;
						end
					end
				end
				csmux_pkg::CSMUX_DACK: begin
					// Only one data byte; then ignore until stop or a new start.
					if (scl_fall) begin
						sda_low <= 1'b0;
						state   <= csmux_pkg::CSMUX_WAIT;
					end
				end
				csmux_pkg::CSMUX_WAIT: begin
					sda_low <= 1'b0;
				end
				default: begin
					state <= csmux_pkg::CSMUX_IDLE;
				end
				endcase
			end
		end
	end
	// ------------------------------------------------------------------
	// Store and output selection.
	// ------------------------------------------------------------------
	csmux_store #(.W(SW)) u_store (
		.clk_i     (clk_i),
		.nv_rstn_i (nv_erase_n_i),
		.we_i      (st_we),
		.wdata_i   (shreg[SW-1:0]),
		.rdata_o   (store_q)
	);
	// Held latch: follows store while select low, frozen while high.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			held_q <= store_q[`CSMUX_HELD_BIT];
		end else if (!pins.source_select) begin
			held_q <= store_q[`CSMUX_HELD_BIT];
		end
	end
	wire force_zero = ~pins.force_n & ~pins.source_select;
	wire [4:0] next_sel = pins.source_select ? pins.bypass_inputs
		: store_q[`CSMUX_SEL_MSB:`CSMUX_SEL_LSB];
	// Output registers, refreshed every cycle from the synchronised pins, the store and the held latch.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			selected_outputs_o <= 5'h00;
			held_output_o      <= 1'b0;
		end else begin
			selected_outputs_o <= force_zero ? 5'h00 : next_sel;
			held_output_o <= force_zero ? 1'b0 :
				(pins.source_select ? held_q : store_q[`CSMUX_HELD_BIT]);
		end
	end
	// Open drain: enable only to pull low, data pin tied low.
	assign selected_outputs_oe_o = ~selected_outputs_o;
	assign held_output_oe_o      = ~held_output_o;
	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_low;
	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	sel_store_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(pins.force_n && !pins.source_select) |=>
		selected_outputs_o == $past(store_q[4:0]))
		else $error("selected outputs not from store");
	sel_bypass_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		pins.source_select |=>
		selected_outputs_o == $past(pins.bypass_inputs))
		else $error("selected outputs not from bypass");
	held_latch_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(pins.source_select && $past(pins.source_select)) |->
		$stable(held_q))
		else $error("held latch moved while closed");
	held_store_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(pins.force_n && !pins.source_select) |=>
		held_output_o == $past(store_q[`CSMUX_HELD_BIT]))
		else $error("held output not from store");
	force_zero_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(!pins.force_n && !pins.source_select) |=>
		(selected_outputs_o == 5'h00 && !held_output_o))
		else $error("force did not zero outputs");
	force_bypass_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(!pins.force_n && pins.source_select) |=>
		held_output_o == $past(held_q))
		else $error("held output not kept under force");
	lock_write_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(pins.write_lock || !sup_s) |=> !st_we)
		else $error("write while locked");
	store_hold_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(!st_we && nv_erase_n_i) |=> $stable(store_q))
		else $error("store changed without a write");
	write_dir_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		st_we |-> !rw)
		else $error("write with read direction");
	store_write_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(st_we && nv_erase_n_i) |=> store_q == $past(shreg[SW-1:0]))
		else $error("store did not take the data byte");
	addr_miss_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(state == csmux_pkg::CSMUX_ADDR && scl_fall && addr_full
		&& !addr_hit) |=> !sda_oe_o)
		else $error("foreign address acknowledged");
	one_byte_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		st_we |-> state == csmux_pkg::CSMUX_DACK)
		else $error("write outside the data acknowledge");
	byte_end_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		state == csmux_pkg::CSMUX_WAIT |-> !sda_oe_o)
		else $error("data line driven after the data byte");
	addr_ack_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		state == csmux_pkg::CSMUX_AACK |-> sda_oe_o)
		else $error("address not acknowledged");
	open_drain_a: assert property (
		@(posedge clk_i) disable iff (!resetn_i)
		(selected_outputs_oe_o == ~selected_outputs_o)
		&& (held_output_oe_o != held_output_o))
		else $error("output not open drain");
	cov_write_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		st_we);
	cov_read_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		state == csmux_pkg::CSMUX_DATA && rw);
	cov_force_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		force_zero ##1 pins.source_select);
endmodule : csmux_top
`default_nettype wire

// ### verif/csmux_i2c_master.sv
`default_nettype none
module csmux_i2c_master (
	output var  logic scl_o,
	output var  logic sda_low_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// SCL stands high and SDA is released between frames.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// One bit: SDA moves only while SCL is low, read just before the fall.
	task automatic bit_x(input logic b, output logic r);
		scl_o = 1'b0;
		#16 sda_low_o = ~b;
		#2 scl_o = 1'b1;
		#12 r = sda_i;
		#2;
	endtask : bit_x
	// START, address byte, acknowledge, one data byte, STOP.
	task automatic xfer(input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic aa, output logic da);
		logic r;
		sda_low_o = 1'b1;
		#16;
		for (int i = 7; i >= 0; i--) begin
			bit_x(a[i], r);
		end
		bit_x(1'b1, r);
		aa = ~r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(a[0] | d[i], r);
			q[i] = r;
		end
		bit_x(1'b1, r); // A read ends with a not-acknowledge.
		da = ~r;
		scl_o = 1'b0;
		#16 sda_low_o = 1'b1;
		#2 scl_o = 1'b1;
		#14 sda_low_o = 1'b0;
		#16;
	endtask : xfer
endmodule : csmux_i2c_master
`default_nettype wire

// ### verif/csmux_tb_top.sv
`default_nettype none
`include "csmux_cfg.svh"
module csmux_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] ADR = {`CSMUX_ADDR_FIXED, 2'b10, 1'b0};
	logic       clk_i, resetn_i, sup, frc_n, lock, sel, scl, m_low;
	logic       sda_oe, held, held_oe, aa, da;
	logic       erase_n, sd_o;
	logic [4:0] byp, so, so_oe;
	logic [7:0] rq;
	int         fails, compares;
	wire        sda;
	// Pulled-up wire: low while either party pulls it.
	assign sda = ~(m_low | (sda_oe & ~sd_o));
	csmux_i2c_master M (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
	csmux_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .nv_erase_n_i(erase_n),
		.supply_ok_i(sup), .scl_i(scl), .sda_i(sda), .sda_o(sd_o),
		.sda_oe_o(sda_oe), .bus_addr_pin_low_i(1'b0),
		.bus_addr_pin_high_i(1'b1), .force_n_i(frc_n),
		.write_lock_i(lock), .source_select_i(sel), .bypass_inputs_i(byp),
		.selected_outputs_o(so), .selected_outputs_oe_o(so_oe),
		.held_output_o(held), .held_output_oe_o(held_oe));
	// Clock of 4 ns.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic eq8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : eq8
	// Pin values and open-drain enables against one six-bit value.
	task automatic outs(input logic [5:0] e);
		#1;
		eq8({2'b00, held, so}, {2'b00, e});
		eq8({2'b11, held_oe, so_oe}, ~{2'b00, e});
	endtask : outs
	task automatic xf(input logic [7:0] a, input logic [7:0] d,
		input logic ea);
		@(posedge clk_i);
		#1 M.xfer(a, d, rq, aa, da);
		eq8({7'h00, aa}, {7'h00, ea});
		if (ea && !a[0]) eq8({7'h00, da}, 8'h01);
		repeat (8) @(posedge clk_i);
	endtask : xf
	task automatic pins(input logic f, input logic s, input logic [4:0] b);
		@(posedge clk_i);
		#1 frc_n = f;
		sel = s;
		byp = b;
		repeat (8) @(posedge clk_i);
	endtask : pins
	task automatic t_reset;
		outs(6'h00);
		xf(ADR | 8'h01, 8'h00, 1'b1);
		eq8(rq, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_write;
		xf(ADR, 8'hea, 1'b1);
		outs(6'h2a);
		xf(ADR | 8'h01, 8'h00, 1'b1);
		eq8(rq, 8'h2a);
		$display("test write done");
	endtask : t_write
	task automatic t_refuse;
		@(posedge clk_i);
		#1 lock = 1'b1;
		xf(ADR, 8'h15, 1'b1);
		@(posedge clk_i);
		#1 lock = 1'b0;
		sup = 1'b0;
		xf(ADR, 8'h15, 1'b1);
		@(posedge clk_i);
		#1 sup = 1'b1;
		xf(8'h9a, 8'h15, 1'b0);
		xf(ADR | 8'h01, 8'h00, 1'b1);
		eq8(rq, 8'h2a);
		outs(6'h2a);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_select;
		pins(1'b1, 1'b1, 5'h15);
		outs(6'h35);
		xf(ADR, 8'h1f, 1'b1);
		outs(6'h35);
		pins(1'b0, 1'b1, 5'h0e);
		outs(6'h2e);
		pins(1'b0, 1'b0, 5'h0e);
		outs(6'h00);
		pins(1'b1, 1'b0, 5'h1f);
		outs(6'h1f);
		$display("test select done");
	endtask : t_select
	task automatic t_power;
		@(posedge clk_i);
		#1 resetn_i = 1'b0;
		repeat (6) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		repeat (8) @(posedge clk_i);
		outs(6'h1f);
		xf(ADR | 8'h01, 8'h00, 1'b1);
		eq8(rq, 8'h1f);
		$display("test power done");
	endtask : t_power
	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// Undriven pins would read high, so force and bypass pins start at one; lock and select start at zero.
	initial begin
		fails = 0;
		compares = 0;
		resetn_i = 1'b0;
		erase_n = 1'b0;
		sup = 1'b1;
		frc_n = 1'b1;
		lock = 1'b0;
		sel = 1'b0;
		byp = 5'h1f;
		repeat (6) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		erase_n = 1'b1;
		pins(1'b1, 1'b0, 5'h1f);
		t_reset();
		t_write();
		t_refuse();
		t_select();
		t_power();
		results();
	end
	// Watchdog against a hang.
	initial begin
		#200000;
		fails++;
		results();
	end
endmodule : csmux_tb_top
`default_nettype wire
